// [core/ustx_regs.svh]
`ifndef USTX_REGS_SVH
`define USTX_REGS_SVH
// Register byte offsets
`define USTX_DATA_OFS      8'h00
`define USTX_STATUS_OFS    8'h04
`define USTX_CONTROL_OFS   8'h08
`define USTX_FORMAT_OFS    8'h0C
`define USTX_BAUD_OFS      8'h10
// Status fields
`define USTX_ST_PE_BIT     2
`define USTX_ST_DOR_BIT    3
`define USTX_ST_FE_BIT     4
`define USTX_ST_UDRE_BIT   5
`define USTX_ST_TXC_BIT    6
`define USTX_ST_RXC_BIT    7
// Control fields
`define USTX_CT_TX8_BIT    0
`define USTX_CT_RX8_BIT    1
`define USTX_CT_TXEN_BIT   3
`define USTX_CT_RXEN_BIT   4
`define USTX_CT_UDRIE_BIT  5
`define USTX_CT_TXCIE_BIT  6
// Format fields
`define USTX_FM_SIZE_LSB   0
`define USTX_FM_PODD_BIT   3
`define USTX_FM_PEN_BIT    4
`define USTX_FM_STOP2_BIT  5
`define USTX_FM_SYNC_BIT   6
// Reset values and fixed constants
`define USTX_FORMAT_RST    8'h06
`define USTX_BAUD_RST      12'h000
`define USTX_SIZE_NINE     3'h7
`define USTX_OVERSAMPLE    4'hF
`define USTX_HALF_SAMPLE   4'h7
`endif

// [core/ustx_pkg.sv]
package ustx_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ustx_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} ustx_rx_e;
endpackage : ustx_pkg

// [core/ustx_top.sv]
`timescale 1ns/10ps
`include "ustx_regs.svh"
module ustx_top #(
  parameter int BAUD_W = 12
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // AXI4-Lite write
  input  wire logic [7:0]        s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]        s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // Serial pins
  input  wire logic              rxd_in,
  input  wire logic              transfer_clock_pin_in,
  output logic                   txd_out,
  output logic                   txd_oe_n_out,
  output logic                   rxd_claim_out,
  // Interrupt requests
  output logic                   tx_buffer_empty_irq_out,
  output logic                   tx_complete_irq_out,
  input  wire logic              tx_complete_irq_ack_in
);
  import ustx_pkg::*;

  initial begin
    if (BAUD_W < 1 || BAUD_W > 16) $error("BAUD_W out of range");
  end

  // ==========================================================
  // Synchronisers
  logic [1:0] rxd_sync_q;
  logic [1:0] xck_sync_q;
  logic       xck_prev_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rxd_sync_q <= 2'h3;
      xck_sync_q <= 2'h0;
      xck_prev_q <= 1'b0;
    end else begin
      rxd_sync_q <= {rxd_sync_q[0], rxd_in};
      xck_sync_q <= {xck_sync_q[0], transfer_clock_pin_in};
      xck_prev_q <= xck_sync_q[1];
    end
  end
  wire logic rxd_s = rxd_sync_q[1];
  wire logic xck_rise = xck_sync_q[1] & ~xck_prev_q;
  wire logic xck_fall = ~xck_sync_q[1] & xck_prev_q;

  // ==========================================================
  // Registers
  logic              tx8_q, txen_q, rxen_q, udrie_q, txcie_q;
  logic [2:0]        size_q;
  logic              podd_q, pen_q, stop2_q, sync_q;
  logic [BAUD_W-1:0] baud_q;
  logic              txc_q;
  logic [8:0]        txbuf_q;
  logic              txbuf_full_q;

  // ==========================================================
  // AXI4-Lite handshakes
  logic       aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  wire logic do_wr = aw_got_q & w_got_q & ~s_axi_bvalid_out;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_got_q         <= 1'b0;
      w_got_q          <= 1'b0;
      awaddr_q         <= 8'h00;
      wdata_q          <= 32'h0000_0000;
      wstrb_q          <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= 2'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        aw_got_q         <= 1'b0;
        w_got_q          <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (awaddr_q > `USTX_BAUD_OFS || awaddr_q[1:0] != 2'h0) ?
                            2'h2 : 2'h0;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end
  assign s_axi_awready_out = ~aw_got_q & ~s_axi_bvalid_out;
  assign s_axi_wready_out  = ~w_got_q & ~s_axi_bvalid_out;
  wire logic wr_lo = do_wr & wstrb_q[0];
  wire logic wr_data = wr_lo & (awaddr_q == `USTX_DATA_OFS);
  wire logic wr_stat = wr_lo & (awaddr_q == `USTX_STATUS_OFS);
  wire logic wr_ctrl = wr_lo & (awaddr_q == `USTX_CONTROL_OFS);
  wire logic wr_fmt  = wr_lo & (awaddr_q == `USTX_FORMAT_OFS);
  wire logic wr_baud = do_wr & (awaddr_q == `USTX_BAUD_OFS);

  // Bit mask for the configured character width
  function automatic logic [8:0] size_mask(input logic [2:0] sz);
    case (sz)
      3'h0:    size_mask = 9'h01F;
      3'h1:    size_mask = 9'h03F;
      3'h2:    size_mask = 9'h07F;
      3'h7:    size_mask = 9'h1FF;
      default: size_mask = 9'h0FF;
    endcase
  endfunction : size_mask
  function automatic logic [3:0] data_bits(input logic [2:0] sz);
    case (sz)
      3'h0:    data_bits = 4'h5;
      3'h1:    data_bits = 4'h6;
      3'h2:    data_bits = 4'h7;
      3'h7:    data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction : data_bits

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx8_q <= 1'b0; txen_q <= 1'b0; rxen_q <= 1'b0;
      udrie_q <= 1'b0; txcie_q <= 1'b0;
      size_q <= 3'(`USTX_FORMAT_RST);
      podd_q <= 1'b0; pen_q <= 1'b0; stop2_q <= 1'b0; sync_q <= 1'b0;
      baud_q <= BAUD_W'(`USTX_BAUD_RST);
    end else begin
      if (wr_ctrl) begin
        tx8_q   <= wdata_q[`USTX_CT_TX8_BIT];
        txen_q  <= wdata_q[`USTX_CT_TXEN_BIT];
        rxen_q  <= wdata_q[`USTX_CT_RXEN_BIT];
        udrie_q <= wdata_q[`USTX_CT_UDRIE_BIT];
        txcie_q <= wdata_q[`USTX_CT_TXCIE_BIT];
      end
      if (wr_fmt) begin
        size_q  <= wdata_q[`USTX_FM_SIZE_LSB +: 3];
        podd_q  <= wdata_q[`USTX_FM_PODD_BIT];
        pen_q   <= wdata_q[`USTX_FM_PEN_BIT];
        stop2_q <= wdata_q[`USTX_FM_STOP2_BIT];
        sync_q  <= wdata_q[`USTX_FM_SYNC_BIT];
      end
      if (wr_baud) baud_q <= wdata_q[BAUD_W-1:0];
    end
  end

  // ==========================================================
  // Bit-rate tick (16x oversample; sync uses pin edges)
  logic [BAUD_W-1:0] div_q;
  logic              tick_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == '0);
      div_q  <= (div_q == '0) ? baud_q : div_q - 1'b1;
    end
  end

  // ==========================================================
  // Transmitter
  ustx_tx_e   tx_st_q;
  logic [3:0] tx_os_q;
  logic [3:0] tx_cnt_q;
  logic [11:0] tx_sh_q;
  logic        tx_active_q;
  wire logic tx_bit_tick = sync_q ? xck_rise : (tick_q && tx_os_q == 4'h0);
  wire logic [3:0] tx_len = 4'h1 + data_bits(size_q) + {3'h0, pen_q} +
                            (stop2_q ? 4'h2 : 4'h1);
  wire logic [8:0] tx_chr = txbuf_q & size_mask(size_q);
  wire logic tx_par = ^tx_chr ^ podd_q;
  logic [11:0] tx_frame;
  always_comb begin
    tx_frame = 12'hFFF;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < data_bits(size_q)) tx_frame[i+1] = tx_chr[i];
    end
    if (pen_q) tx_frame[data_bits(size_q)+1] = tx_par;
  end
  wire logic tx_done = (tx_st_q == TX_SHIFT) && tx_bit_tick && tx_cnt_q == 4'h1;
  wire logic tx_load = txbuf_full_q && txen_q &&
                       (tx_st_q == TX_IDLE || tx_done);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      txbuf_q      <= 9'h000;
      txbuf_full_q <= 1'b0;
    end else begin
      if (wr_data) begin
        txbuf_q      <= {tx8_q, wdata_q[7:0]};
        txbuf_full_q <= 1'b1;
      end else if (tx_load) begin
        txbuf_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st_q <= TX_IDLE;
      tx_os_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      tx_sh_q <= 12'hFFF;
    end else begin
      if (tick_q) tx_os_q <= tx_os_q + 4'h1;
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_load) begin
            tx_sh_q  <= tx_frame;
            tx_cnt_q <= tx_len;
            tx_st_q  <= TX_SHIFT;
            tx_os_q  <= 4'h1;
          end
        end
        TX_SHIFT: begin
          if (tx_load) begin
            tx_sh_q  <= tx_frame;
            tx_cnt_q <= tx_len;
          end else if (tx_done) begin
            tx_st_q <= TX_IDLE;
            tx_sh_q <= 12'hFFF;
          end else if (tx_bit_tick) begin
            tx_sh_q  <= {1'b1, tx_sh_q[11:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Pin stays claimed while the transmitter is enabled, and after that until shifter and buffer drain
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_active_q  <= 1'b0;
      txd_out      <= 1'b1;
      txd_oe_n_out <= 1'b1;
    end else begin
      tx_active_q  <= txen_q | txbuf_full_q | (tx_st_q != TX_IDLE);
      txd_oe_n_out <= ~(txen_q | txbuf_full_q | (tx_st_q != TX_IDLE));
      txd_out      <= (tx_st_q == TX_SHIFT) ? tx_sh_q[0] : 1'b1;
    end
  end

  // Set wins over clear for the complete flag
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      txc_q <= 1'b0;
    end else if (tx_done && !txbuf_full_q) begin
      txc_q <= 1'b1;
    end else if ((wr_stat && wdata_q[`USTX_ST_TXC_BIT]) ||
                 (tx_complete_irq_ack_in && txcie_q)) begin
      txc_q <= 1'b0;
    end
  end

  // ==========================================================
  // Receiver
  ustx_rx_e    rx_st_q;
  logic [3:0]  rx_os_q;
  logic [3:0]  rx_cnt_q;
  logic [9:0]  rx_sh_q;
  logic        rx_pend_q;
  logic [11:0] rx_pend_word_q;
  logic [11:0] rxq_q [2];
  logic [1:0]  rxq_cnt_q;
  logic        rxq_rd_q;
  logic        dor_q;
  wire logic rx_sample = sync_q ? xck_fall : (tick_q && rx_os_q == `USTX_HALF_SAMPLE);
  wire logic [3:0] rx_need = data_bits(size_q) + {3'h0, pen_q};
  wire logic rx_start = rxen_q && rx_st_q == RX_IDLE &&
                        (sync_q ? (xck_fall && !rxd_s) : !rxd_s);
  wire logic rd_data;
  wire logic rxq_pop = rd_data && rxq_cnt_q != 2'h0;
  wire logic rx_stop = rx_st_q == RX_SHIFT && rx_sample && rx_cnt_q == rx_need;
  logic [8:0] rx_chr;
  logic       rx_perr;
  always_comb begin
    rx_chr  = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < data_bits(size_q)) rx_chr[i] = rx_sh_q[i];
    end
    rx_perr = pen_q & (^rx_chr ^ podd_q ^ rx_sh_q[data_bits(size_q)]);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_q  <= RX_IDLE;
      rx_os_q  <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_sh_q  <= 10'h000;
    end else if (!rxen_q) begin
      rx_st_q <= RX_IDLE;
    end else begin
      if (tick_q) rx_os_q <= rx_os_q + 4'h1;
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_start) begin
            rx_st_q  <= RX_SHIFT;
            rx_cnt_q <= sync_q ? 4'h0 : 4'hF;
            if (!sync_q) rx_os_q <= 4'h0;
          end
        end
        RX_SHIFT: begin
          if (rx_stop) begin
            rx_st_q <= RX_IDLE;
          end else if (rx_sample && rx_cnt_q == 4'hF) begin
            if (rxd_s) rx_st_q <= RX_IDLE;
            rx_cnt_q <= 4'h0;
          end else if (rx_sample) begin
            rx_sh_q[rx_cnt_q] <= rxd_s;
            rx_cnt_q <= rx_cnt_q + 4'h1;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Queue word: {dor, fe, pe, ninth, byte}
  wire logic [11:0] rx_word = {1'b0, ~rxd_s, rx_perr, rx_chr};
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rxq_q[0]       <= 12'h000;
      rxq_q[1]       <= 12'h000;
      rxq_cnt_q      <= 2'h0;
      rx_pend_q      <= 1'b0;
      rx_pend_word_q <= 12'h000;
      dor_q          <= 1'b0;
    end else if (!rxen_q) begin
      rxq_cnt_q <= 2'h0;
      rx_pend_q <= 1'b0;
      dor_q     <= 1'b0;
    end else begin
      logic [1:0] cnt;
      logic       push;
      logic [11:0] word;
      cnt  = rxq_cnt_q;
      push = 1'b0;
      word = rx_pend_word_q;
      if (rxq_pop) begin
        rxq_q[0] <= rxq_q[1];
        cnt = cnt - 2'h1;
      end
      if (rx_stop) begin
        rx_pend_word_q <= {dor_q, rx_word[10:0]};
        rx_pend_q      <= 1'b1;
        if (!rx_pend_q) word = {dor_q, rx_word[10:0]};
      end
      if ((rx_pend_q || rx_stop) && cnt != 2'h2 && !(rx_pend_q && rx_stop)) begin
        push = 1'b1;
        rx_pend_q <= 1'b0;
        dor_q <= 1'b0;
      end
      if (rx_start && rx_pend_q && cnt == 2'h2) dor_q <= 1'b1;
      if (push) begin
        rxq_q[cnt[0]] <= word;
        cnt = cnt + 2'h1;
      end
      rxq_cnt_q <= cnt;
    end
  end

  // ==========================================================
  // Read channel
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr_in)
      `USTX_DATA_OFS:    rd_val[7:0] = 8'(rxq_q[0][8:0] & size_mask(size_q));
      `USTX_STATUS_OFS: begin
        rd_val[`USTX_ST_RXC_BIT]  = rxq_cnt_q != 2'h0;
        rd_val[`USTX_ST_TXC_BIT]  = txc_q;
        rd_val[`USTX_ST_UDRE_BIT] = ~txbuf_full_q;
        rd_val[`USTX_ST_FE_BIT]   = rxq_q[0][10];
        rd_val[`USTX_ST_DOR_BIT]  = rxq_q[0][11];
        rd_val[`USTX_ST_PE_BIT]   = rxq_q[0][9];
      end
      `USTX_CONTROL_OFS: begin
        rd_val[`USTX_CT_TX8_BIT]   = tx8_q;
        rd_val[`USTX_CT_RX8_BIT]   = rxq_q[0][8];
        rd_val[`USTX_CT_TXEN_BIT]  = txen_q;
        rd_val[`USTX_CT_RXEN_BIT]  = rxen_q;
        rd_val[`USTX_CT_UDRIE_BIT] = udrie_q;
        rd_val[`USTX_CT_TXCIE_BIT] = txcie_q;
      end
      `USTX_FORMAT_OFS:
        rd_val[6:0] = {sync_q, stop2_q, pen_q, podd_q, size_q};
      `USTX_BAUD_OFS:    rd_val[BAUD_W-1:0] = baud_q;
      default:           rd_val = 32'h0000_0000;
    endcase
  end
  wire logic ar_take = s_axi_arvalid_in & s_axi_arready_out;
  assign rd_data = ar_take && s_axi_araddr_in == `USTX_DATA_OFS;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= 2'h0;
      rxq_rd_q         <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= rd_val;
      s_axi_rresp_out  <= (s_axi_araddr_in > `USTX_BAUD_OFS ||
                           s_axi_araddr_in[1:0] != 2'h0) ? 2'h2 : 2'h0;
      rxq_rd_q         <= rd_data;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
  assign s_axi_arready_out = ~s_axi_rvalid_out;

  // ==========================================================
  // Interrupts and pin claim
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_buffer_empty_irq_out <= 1'b0;
      tx_complete_irq_out     <= 1'b0;
      rxd_claim_out           <= 1'b0;
    end else begin
      tx_buffer_empty_irq_out <= udrie_q & ~txbuf_full_q & ~wr_data;
      tx_complete_irq_out     <= txcie_q & (txc_q | (tx_done & ~txbuf_full_q));
      rxd_claim_out           <= rxen_q;
    end
  end
endmodule : ustx_top

// [tb/ustx_top_properties.sv]
`timescale 1ns/10ps
// ============
// Port checker
module ustx_top_properties #(
  parameter int BAUD_W = 12
) (
  // Clock, reset and bus
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic [7:0]  s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  // Serial side
  input wire logic        txd_out,
  input wire logic        txd_oe_n_out,
  input wire logic        tx_complete_irq_out,
  input wire logic        tx_complete_irq_ack_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] ar_q;
  // Address of the read under way, for judging its answer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) ar_q <= 8'h00;
    else if (s_axi_arvalid_in && s_axi_arready_out) ar_q <= s_axi_araddr_in;
  end
  a_line_idle_off: assert property (txd_oe_n_out |-> txd_out)
    else $error("line low while released");
  a_bit_min_len: assert property ($changed(txd_out) && !txd_oe_n_out |=> $stable(txd_out)[*3])
    else $error("serial bit too short");
  a_release_stop: assert property ($rose(txd_oe_n_out) |-> txd_out && $past(txd_out, 4))
    else $error("pin released inside a frame");
  a_txc_at_idle: assert property ($rose(tx_complete_irq_out) |-> txd_out && $past(txd_out))
    else $error("complete raised before stop bit");
  a_txc_ack_clear: assert property (tx_complete_irq_ack_in && tx_complete_irq_out
    |-> ##[1:2] !tx_complete_irq_out)
    else $error("complete not cleared by service");
  a_wr_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
    else $error("write not answered");
  a_rd_resp_code: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out
    && s_axi_rresp_out == ((ar_q > 8'h10 || ar_q[1:0] != 2'h0) ? 2'h2 : 2'h0))
    else $error("read answer wrong");
  a_data_upper_zero: assert property (s_axi_rvalid_out && ar_q == 8'h00
    |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("data read upper bits set");
endmodule : ustx_top_properties

bind ustx_top ustx_top_properties #(.BAUD_W(BAUD_W)) ustx_top_properties_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .txd_out(txd_out), .txd_oe_n_out(txd_oe_n_out), .tx_complete_irq_out(tx_complete_irq_out),
  .tx_complete_irq_ack_in(tx_complete_irq_ack_in));

// [tb/ustx_far_end.sv]
`timescale 1ns/10ps
// ============
// Remote serial device
module ustx_far_end (
  // Clock and line
  input  wire logic clk_in,
  input  wire logic txd_in,
  input  wire logic txd_oe_n_in,
  output logic      rxd_out,
  output logic      xck_out
);
  int          bt   = 16;
  int          nb   = 8;
  int          k    = 0;
  bit          par  = 1'b0;
  bit          odd  = 1'b0;
  bit          sync = 1'b0;
  logic [11:0] sv;
  int          got[$];
  initial begin
    rxd_out = 1'b1;
    xck_out = 1'b0;
  end
  // Link clock runs only inside bit slots
  task automatic slot(input logic b);
    if (sync) begin
      xck_out <= 1'b1;
      rxd_out <= b;
      repeat (4) @(posedge clk_in);
      xck_out <= 1'b0;
      repeat (4) @(posedge clk_in);
    end else begin
      rxd_out <= b;
      repeat (bt) @(posedge clk_in);
    end
  endtask : slot
  task automatic frame(input int v, input bit bad, input int idle);
    int m;
    m = (1 << nb) - 1;
    @(posedge clk_in);
    slot(1'b0);
    for (int i = 0; i < nb; i++) slot(v[i]);
    if (par) slot((^(v & m)) ^ odd);
    slot(!bad);
    repeat (idle) slot(1'b1);
  endtask : frame
  // Async capture: mid-bit sampling from the start edge
  always begin
    @(negedge txd_in);
    if (!sync && !txd_oe_n_in) begin
      repeat (bt / 2) @(posedge clk_in);
      sv = 12'h000;
      for (int i = 0; i < nb + par; i++) begin
        repeat (bt) @(posedge clk_in);
        sv[i] = txd_in;
      end
      repeat (bt) @(posedge clk_in);
      sv[11] = txd_in;
      got.push_back(sv);
    end
  end
  // Sync capture on the rising link clock edge
  always @(posedge xck_out) begin
    if (sync && k > nb) begin
      sv[11] = txd_in;
      got.push_back(sv);
      k = 0;
    end else if (sync && k > 0) begin
      sv[k-1] = txd_in;
      k++;
    end else if (sync && !txd_in && !txd_oe_n_in) begin
      sv = 12'h000;
      k = 1;
    end
  end
endmodule : ustx_far_end

// [tb/tb_ustx_top.sv]
`timescale 1ns/10ps
`include "ustx_regs.svh"
// ============
// Bench top
module tb_ustx_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        ack = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        rxd, transfer_clock_pin, txd, oe_n, claim, irq_e, irq_c;
  logic [1:0]  bresp, rresp, lr;
  logic [31:0] rdata, r;
  int          mismatches = 0;
  int          total_checks = 0;
  int          v[4];
  int          ex[$];
  initial forever #25 clk = ~clk;
  ustx_top ustx_top_i (
    .clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .rxd_in(rxd), .transfer_clock_pin_in(transfer_clock_pin), .txd_out(txd), .txd_oe_n_out(oe_n),
    .rxd_claim_out(claim), .tx_buffer_empty_irq_out(irq_e), .tx_complete_irq_out(irq_c),
    .tx_complete_irq_ack_in(ack));
  ustx_far_end ustx_far_end_i (
    .clk_in(clk), .txd_in(txd), .txd_oe_n_in(oe_n), .rxd_out(rxd), .xck_out(transfer_clock_pin));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      t++;
    end while (!bvalid && t < 100);
    bready <= 1'b0;
    @(posedge clk);
    if (t >= 100) chk(32'h0, 32'h1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      d = rdata;
      lr = rresp;
      t++;
    end while (!rvalid && t < 100);
    rready <= 1'b0;
    if (t >= 100) chk(32'h0, 32'h1);
  endtask : rd
  function automatic int enc(int d, int n, bit p, bit o);
    int m;
    m = (1 << n) - 1;
    return (d & m) | (p ? (((^(d & m)) ^ o) << n) : 0) | 32'h800;
  endfunction : enc
  task automatic tx_eq();
    for (int t = 0; t < 4000 && ustx_far_end_i.got.size() == 0; t++) @(posedge clk);
    if (ustx_far_end_i.got.size() == 0) chk(32'h0, 32'h1);
    else chk(ustx_far_end_i.got.pop_front(), ex.pop_front());
    repeat (20) @(posedge clk);
  endtask : tx_eq
  initial begin
    #(50 * 40000);
    mismatches++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h68D6226D));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wr(`USTX_BAUD_OFS, 32'h0);
    ustx_far_end_i.nb = 7;
    ustx_far_end_i.par = 1'b1;
    wr(`USTX_FORMAT_OFS, 32'h12);
    wr(`USTX_CONTROL_OFS, 32'h78);
    chk(oe_n, 1'b0);
    chk(claim, 1'b1);
    chk(irq_e, 1'b1);
    // 7-bit frame drops bit 7
    for (int i = 0; i < 2; i++) begin
      v[i] = $urandom | 32'h80;
      wr(`USTX_DATA_OFS, v[i] & 32'hFF);
      ex.push_back(enc(v[i], 7, 1'b1, 1'b0));
    end
    rd(`USTX_STATUS_OFS, r);
    chk(r[5], 1'b0);
    chk(irq_e, 1'b0);
    tx_eq();
    tx_eq();
    chk(irq_c, 1'b1);
    rd(`USTX_STATUS_OFS, r);
    chk(r & 32'h60, 32'h60);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (3) @(posedge clk);
    chk(irq_c, 1'b0);
    wr(`USTX_CONTROL_OFS, 32'h18);
    chk(irq_e, 1'b0);
    ustx_far_end_i.nb = 8;
    ustx_far_end_i.odd = 1'b1;
    wr(`USTX_FORMAT_OFS, 32'h1B);
    v[0] = $urandom & 32'hFF;
    wr(`USTX_DATA_OFS, v[0]);
    ex.push_back(enc(v[0], 8, 1'b1, 1'b1));
    tx_eq();
    rd(`USTX_STATUS_OFS, r);
    chk(r[6], 1'b1);
    wr(`USTX_STATUS_OFS, 32'h40);
    rd(`USTX_STATUS_OFS, r);
    chk(r[6], 1'b0);
    // Disable while a frame is still going out
    v[0] = $urandom & 32'hFF;
    wr(`USTX_DATA_OFS, v[0]);
    ex.push_back(enc(v[0], 8, 1'b1, 1'b1));
    wr(`USTX_CONTROL_OFS, 32'h10);
    chk(oe_n, 1'b0);
    tx_eq();
    chk(oe_n, 1'b1);
    ustx_far_end_i.nb = 9;
    ustx_far_end_i.par = 1'b0;
    wr(`USTX_FORMAT_OFS, 32'h7);
    wr(`USTX_CONTROL_OFS, 32'h19);
    v[0] = $urandom & 32'hFF;
    wr(`USTX_DATA_OFS, v[0]);
    ex.push_back(enc(v[0] | 32'h100, 9, 1'b0, 1'b0));
    tx_eq();
    // Receive: good frame, then a broken first stop bit
    ustx_far_end_i.nb = 8;
    wr(`USTX_FORMAT_OFS, 32'h23);
    wr(`USTX_CONTROL_OFS, 32'h10);
    for (int i = 0; i < 2; i++) begin
      v[i] = $urandom & 32'hFF;
      ustx_far_end_i.frame(v[i], i == 1, 2);
    end
    rd(`USTX_STATUS_OFS, r);
    chk(r & 32'h98, 32'h80);
    rd(`USTX_DATA_OFS, r);
    chk(r, v[0]);
    rd(`USTX_STATUS_OFS, r);
    chk(r[4], 1'b1);
    rd(`USTX_DATA_OFS, r);
    chk(r, v[1]);
    rd(`USTX_STATUS_OFS, r);
    chk(r[7], 1'b0);
    // Four frames back to back: overrun
    for (int i = 0; i < 4; i++) begin
      v[i] = $urandom & 32'hFF;
      ustx_far_end_i.frame(v[i], 1'b0, 0);
    end
    rd(`USTX_STATUS_OFS, r);
    chk(r[3], 1'b0);
    rd(`USTX_DATA_OFS, r);
    chk(r, v[0]);
    rd(`USTX_DATA_OFS, r);
    chk(r, v[1]);
    rd(`USTX_STATUS_OFS, r);
    chk(r[3], 1'b1);
    rd(`USTX_DATA_OFS, r);
    rd(`USTX_STATUS_OFS, r);
    chk(r[7], 1'b0);
    // Five-bit and nine-bit characters
    for (int i = 0; i < 2; i++) begin
      wr(`USTX_FORMAT_OFS, i ? 32'h7 : 32'h0);
      ustx_far_end_i.nb = i ? 9 : 5;
      v[0] = $urandom & 32'h1FF;
      ustx_far_end_i.frame(v[0], 1'b0, 1);
      rd(`USTX_CONTROL_OFS, r);
      if (i == 1) chk(r[1], v[0] >> 8);
      rd(`USTX_DATA_OFS, r);
      chk(r, v[0] & (i ? 32'hFF : 32'h1F));
    end
    ustx_far_end_i.nb = 8;
    wr(`USTX_FORMAT_OFS, 32'h3);
    ustx_far_end_i.frame($urandom & 32'hFF, 1'b0, 1);
    wr(`USTX_CONTROL_OFS, 32'h0);
    chk(claim, 1'b0);
    wr(`USTX_CONTROL_OFS, 32'h10);
    rd(`USTX_STATUS_OFS, r);
    chk(r[7], 1'b0);
    rd(8'h14, r);
    chk(lr, 2'h2);
    // Synchronous mode: both directions on the link clock
    ustx_far_end_i.sync = 1'b1;
    wr(`USTX_FORMAT_OFS, 32'h43);
    wr(`USTX_CONTROL_OFS, 32'h18);
    v[0] = $urandom & 32'hFF;
    v[1] = $urandom & 32'hFF;
    wr(`USTX_DATA_OFS, v[0]);
    ex.push_back(enc(v[0], 8, 1'b0, 1'b0));
    ustx_far_end_i.frame(v[1], 1'b0, 4);
    tx_eq();
    rd(`USTX_DATA_OFS, r);
    chk(r, v[1]);
    wrap_up();
  end
endmodule : tb_ustx_top
